//--- verilog/dds_pkg.sv
// Constants shared by the dual channel synthesis coordinator
package dds_pkg;
  // Datapath widths
  localparam int WORD_W = 52;
  localparam int FREQ_W = 32;
  localparam int SAMP_W = 16;
  localparam int ADDR_W = 8;
  localparam int NUM_W = FREQ_W + WORD_W;
  // Synthesis clock, figure in GHz and derived value in Hz
  localparam real SYNTH_CLK_GHZ = 2.5;
  localparam logic [31:0] SYNTH_CLK_HZ = 32'(longint'(SYNTH_CLK_GHZ * 1.0e9));
  localparam logic [WORD_W-1:0] HALF_CLK = WORD_W'(SYNTH_CLK_HZ >> 1);
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PAR_A = 8'h10;
  localparam logic [7:0] OFS_PAR_B = 8'h20;
  localparam logic [7:0] OFS_CPL_FREQ = 8'h30;
  localparam logic [7:0] OFS_CPL_AMP = 8'h34;
  localparam logic [7:0] OFS_CPL_PH = 8'h38;
  localparam logic [7:0] OFS_WA_LO = 8'h40;
  localparam logic [7:0] OFS_WA_HI = 8'h44;
  localparam logic [7:0] OFS_WB_LO = 8'h48;
  localparam logic [7:0] OFS_WB_HI = 8'h4C;
  // Control fields
  localparam int CTRL_LOCK = 0;
  localparam int CTRL_LINK = 1;
  localparam int CTRL_SEL1 = 3;
  localparam int CTRL_SEL2 = 4;
  localparam int CTRL_KIND = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] LINK_NONE = 2'h0;
  localparam logic [1:0] LINK_TRACK = 2'h1;
  localparam logic [1:0] LINK_COUPLE = 2'h2;
  // Command bits
  localparam int CMD_EQ = 0;
  localparam int CMD_CPY_AB = 1;
  localparam int CMD_CPY_BA = 2;
  // Parameter slots and reset values
  localparam logic [1:0] PAR_FREQ = 2'h0;
  localparam logic [1:0] PAR_AMP = 2'h1;
  localparam logic [1:0] PAR_PH = 2'h2;
  localparam logic [31:0] PAR_RST [3] = '{32'h0000_0000, 32'h0000_FFFF, 32'h0000_0000};
  localparam logic [31:0] CPL_RST = 32'h0100_0100;
  // Tuning word calculation sequence
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DIV_A = 5'h02,
    ST_DIV_B = 5'h04,
    ST_RATIO = 5'h08,
    ST_APPLY = 5'h10
  } calc_state_t;
endpackage

//--- verilog/tw_divider.sv
// Sequential restoring divider for tuning word and ratio calculation
`timescale 1ns/1ps
`default_nettype none
module tw_divider #(
  parameter int NUM_W = dds_pkg::NUM_W,
  parameter int DEN_W = dds_pkg::FREQ_W
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic start, // Latch operands, begin
  input wire logic [NUM_W-1:0] num, // Dividend
  input wire logic [DEN_W-1:0] den, // Divisor, nonzero
  output logic done, // One cycle, result valid
  output logic [NUM_W-1:0] quot, // Quotient
  output logic [DEN_W-1:0] rem // Remainder
);
  localparam int CW = $clog2(NUM_W + 1);
  logic [NUM_W-1:0] n_reg, q_reg, num_hold;
  logic [DEN_W-1:0] r_reg, d_reg;
  logic [CW-1:0] cnt_reg;
  logic [DEN_W:0] trial;
  logic fits;

  // One quotient bit per clock
  assign trial = {r_reg, n_reg[NUM_W-1]};
  assign fits = trial >= {1'b0, d_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_reg <= '0;
      q_reg <= '0;
      r_reg <= '0;
      d_reg <= '0;
      num_hold <= '0;
      cnt_reg <= '0;
      done <= 1'b0;
    end else if (start) begin
      n_reg <= num;
      num_hold <= num;
      d_reg <= den;
      q_reg <= '0;
      r_reg <= '0;
      cnt_reg <= CW'(NUM_W);
      done <= 1'b0;
    end else if (cnt_reg != '0) begin
      n_reg <= {n_reg[NUM_W-2:0], 1'b0};
      r_reg <= fits ? DEN_W'(trial - {1'b0, d_reg}) : trial[DEN_W-1:0];
      q_reg <= {q_reg[NUM_W-2:0], fits};
      cnt_reg <= cnt_reg - 1'b1;
      done <= (cnt_reg == CW'(1));
    end else begin
      done <= 1'b0;
    end
  end

  assign quot = q_reg;
  assign rem = r_reg;

  // Exact integer division, rounding carried in the dividend
  div_exact_a: assert property (@(posedge pclk) disable iff (!presetn)
    done |-> ({{DEN_W{1'b0}}, q_reg} * {{NUM_W{1'b0}}, d_reg} + (NUM_W + DEN_W)'(r_reg)
      == (NUM_W + DEN_W)'(num_hold)) && (r_reg < d_reg))
    else $error("divider result inconsistent");
endmodule
`default_nettype wire

//--- verilog/dds_channel.sv
// One synthesis channel: phase accumulator and sample shaping
`timescale 1ns/1ps
`default_nettype none
module dds_channel #(
  parameter int WORD_W = dds_pkg::WORD_W,
  parameter int SAMP_W = dds_pkg::SAMP_W
) (
  input wire logic pclk, // Sample clock
  input wire logic presetn, // Async reset, active low
  input wire logic word_load, // Take new tuning word
  input wire logic [WORD_W-1:0] word_in, // Phase increment word
  input wire logic acc_clear, // Restart accumulator at zero
  input wire logic [15:0] amp, // Amplitude scale, unsigned
  input wire logic [15:0] phase_off, // Phase offset
  output logic [15:0] phase_now, // Accumulator top bits
  output logic signed [SAMP_W-1:0] sample // Output sample
);
  logic [WORD_W-1:0] word_reg, acc_reg;
  logic [15:0] ph_idx;
  logic signed [32:0] prod;

  // Active phase increment word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_reg <= '0;
    end else if (word_load) begin
      word_reg <= word_in;
    end
  end

  // Accumulator wraps modulo two to the word width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= '0;
    end else if (acc_clear) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_reg + word_reg;
    end
  end

  // Offset phase read as signed ramp, scaled by amplitude
  assign phase_now = acc_reg[WORD_W-1 -: 16];
  assign ph_idx = phase_now + phase_off;
  assign prod = $signed(ph_idx) * $signed({1'b0, amp});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample <= '0;
    end else begin
      sample <= prod[31:32-SAMP_W];
    end
  end

  acc_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(acc_clear) |-> acc_reg == $past(acc_reg) + $past(word_reg))
    else $error("accumulator did not advance by the word");
endmodule
`default_nettype wire

//--- verilog/dual_dds_coordinator.sv
// Dual channel synthesis coordinator with APB register file and port routing
`timescale 1ns/1ps
`default_nettype none
module dual_dds_coordinator (
  input wire logic pclk, // APB and sample clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [dds_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready, no wait states
  output logic pslverr, // APB error
  output logic signed [dds_pkg::SAMP_W-1:0] port1_sample, // Converter one data
  output logic signed [dds_pkg::SAMP_W-1:0] port2_sample // Converter two data
);
  localparam int WW = dds_pkg::WORD_W;
  localparam int SW = dds_pkg::SAMP_W;
  localparam int NW = dds_pkg::NUM_W;
  localparam logic signed [SW-1:0] SAT_MAX = {1'b0, {(SW-1){1'b1}}};
  localparam logic signed [SW-1:0] SAT_MIN = {1'b1, {(SW-1){1'b0}}};

  logic [7:0] ctrl_reg;
  logic [31:0] par_reg [2][3];
  logic [31:0] cpl_reg [3];
  logic [1:0] link;
  logic locked_eff, apb_fire, wr_fire, par_hit, wr_ch, reject_b, mapped;
  logic cmd_fire, eq_fire, copy_ab, copy_ba, track_entry, timing_wr;
  logic [1:0] wr_par;
  logic [31:0] wval, rd_val, prdata_reg;
  logic [95:0] a_params, b_params;
  dds_pkg::calc_state_t state_reg;
  logic pending_reg, div_start, div_done, ratio_ok_reg, a_high_reg;
  logic load_reg, acc_clear_reg;
  logic [NW-1:0] div_num, div_quot;
  logic [31:0] div_den, div_rem, ratio_reg;
  logic [WW-1:0] word_calc [2];
  logic [WW-1:0] word_act [2];
  logic [WW-1:0] word_ld_a, word_ld_b;
  logic signed [SW-1:0] samp [2];
  logic [15:0] phase_now [2];
  logic signed [SW:0] sum_w;
  logic signed [SW-1:0] sum_sat;

  // Keep amplitude and phase to 16 bits
  function automatic logic [31:0] pmask(input logic [1:0] p, input logic [31:0] v);
    return (p == dds_pkg::PAR_FREQ) ? v : {16'h0000, v[15:0]};
  endfunction

  // Coupling transform, forward toward B or inverse toward A
  function automatic logic [31:0] xform(input logic [31:0] v, input logic [31:0] c,
                                        input logic ofs, input logic to_b);
    logic [47:0] p;
    logic [31:0] off;
    p = 48'(v) * 48'(to_b ? c[15:0] : c[31:16]);
    off = {{16{c[15]}}, c[15:0]};
    if (ofs) begin
      xform = to_b ? v + off : v - off;
    end else begin
      xform = p[39:8];
    end
  endfunction

  // Divider dividend: frequency times 2^52 plus half clock, for rounding
  function automatic logic [NW-1:0] tw_num(input logic [31:0] f);
    logic [31:0] fc;
    fc = (f >= dds_pkg::SYNTH_CLK_HZ) ? dds_pkg::SYNTH_CLK_HZ - 32'h0000_0001 : f;
    return {fc, dds_pkg::HALF_CLK};
  endfunction

  // Bus decode
  assign pready = 1'b1;
  assign apb_fire = psel & penable;
  assign wr_fire = apb_fire & pwrite;
  assign link = ctrl_reg[dds_pkg::CTRL_LINK +: 2];
  assign locked_eff = ctrl_reg[dds_pkg::CTRL_LOCK] | (link == dds_pkg::LINK_TRACK);
  assign par_hit = ((paddr[7:4] == dds_pkg::OFS_PAR_A[7:4]) ||
                    (paddr[7:4] == dds_pkg::OFS_PAR_B[7:4])) &&
                   (paddr[3:2] != 2'h3) && (paddr[1:0] == 2'h0);
  assign wr_ch = paddr[5];
  assign wr_par = paddr[3:2];
  assign wval = pmask(wr_par, pwdata);
  assign reject_b = (link == dds_pkg::LINK_TRACK) & wr_ch;
  assign cmd_fire = wr_fire & (paddr == dds_pkg::OFS_CMD);
  assign eq_fire = cmd_fire & pwdata[dds_pkg::CMD_EQ];
  assign copy_ab = cmd_fire & pwdata[dds_pkg::CMD_CPY_AB];
  assign copy_ba = cmd_fire & pwdata[dds_pkg::CMD_CPY_BA] & ~pwdata[dds_pkg::CMD_CPY_AB];
  assign track_entry = wr_fire & (paddr == dds_pkg::OFS_CTRL) & (link != dds_pkg::LINK_TRACK) &
                       (pwdata[dds_pkg::CTRL_LINK +: 2] == dds_pkg::LINK_TRACK);
  assign timing_wr = (wr_fire & par_hit & ~reject_b & (wr_par != dds_pkg::PAR_AMP)) |
                     copy_ab | copy_ba | track_entry;
  assign pslverr = apb_fire & (~mapped | (pwrite & par_hit & reject_b));
  assign a_params = {par_reg[0][0], par_reg[0][1], par_reg[0][2]};
  assign b_params = {par_reg[1][0], par_reg[1][1], par_reg[1][2]};

  // Read mux and address map
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    if (par_hit) begin
      rd_val = par_reg[wr_ch][wr_par];
    end else begin
      case (paddr)
        dds_pkg::OFS_CTRL: rd_val = {24'h00_0000, ctrl_reg};
        dds_pkg::OFS_CMD: rd_val = 32'h0000_0000;
        dds_pkg::OFS_STATUS: rd_val = {28'h000_0000, locked_eff, ratio_ok_reg, pending_reg,
                                       state_reg != dds_pkg::ST_IDLE};
        dds_pkg::OFS_CPL_FREQ: rd_val = cpl_reg[0];
        dds_pkg::OFS_CPL_AMP: rd_val = cpl_reg[1];
        dds_pkg::OFS_CPL_PH: rd_val = cpl_reg[2];
        dds_pkg::OFS_WA_LO: rd_val = word_act[0][31:0];
        dds_pkg::OFS_WA_HI: rd_val = 32'(word_act[0][WW-1:32]);
        dds_pkg::OFS_WB_LO: rd_val = word_act[1][31:0];
        dds_pkg::OFS_WB_HI: rd_val = 32'(word_act[1][WW-1:32]);
        default: mapped = 1'b0;
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_val;
    end
  end
  assign prdata = prdata_reg;

  // Control and coupling registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= dds_pkg::CTRL_RST;
      for (int i = 0; i < 3; i++) begin
        cpl_reg[i] <= dds_pkg::CPL_RST;
      end
    end else if (wr_fire) begin
      if (paddr == dds_pkg::OFS_CTRL) begin
        ctrl_reg <= pwdata[7:0];
      end
      if (paddr == dds_pkg::OFS_CPL_FREQ) cpl_reg[0] <= pwdata;
      if (paddr == dds_pkg::OFS_CPL_AMP) cpl_reg[1] <= pwdata;
      if (paddr == dds_pkg::OFS_CPL_PH) cpl_reg[2] <= pwdata;
    end
  end

  // Channel parameters: direct, tracked, coupled and copied writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        for (int p = 0; p < 3; p++) begin
          par_reg[c][p] <= dds_pkg::PAR_RST[p];
        end
      end
    end else if (wr_fire && par_hit && !reject_b) begin
      par_reg[wr_ch][wr_par] <= wval;
      if (link == dds_pkg::LINK_TRACK) begin
        par_reg[1][wr_par] <= wval;
      end else if (link == dds_pkg::LINK_COUPLE) begin
        par_reg[~wr_ch][wr_par] <= pmask(wr_par, xform(wval, cpl_reg[wr_par],
          ctrl_reg[dds_pkg::CTRL_KIND + 32'(wr_par)], ~wr_ch));
      end
    end else if (copy_ab || track_entry) begin
      for (int p = 0; p < 3; p++) begin
        par_reg[1][p] <= par_reg[0][p];
      end
    end else if (copy_ba) begin
      for (int p = 0; p < 3; p++) begin
        par_reg[0][p] <= par_reg[1][p];
      end
    end
  end

  // Recalculation request, a new write wins over the take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= timing_wr | (pending_reg & (state_reg != dds_pkg::ST_IDLE));
    end
  end

  // Locked words: higher is the exact multiple of the lower when the frequency ratio leaves no remainder
  assign word_ld_a = (ratio_ok_reg && a_high_reg) ? WW'(ratio_reg * word_calc[1]) : word_calc[0];
  assign word_ld_b = (ratio_ok_reg && !a_high_reg) ? WW'(ratio_reg * word_calc[0]) : word_calc[1];

  // Tuning word sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= dds_pkg::ST_IDLE;
      div_start <= 1'b0;
      div_num <= '0;
      div_den <= 32'h0000_0000;
      ratio_ok_reg <= 1'b0;
      a_high_reg <= 1'b0;
      ratio_reg <= 32'h0000_0000;
      load_reg <= 1'b0;
      acc_clear_reg <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        word_calc[c] <= '0;
        word_act[c] <= '0;
      end
    end else begin
      div_start <= 1'b0;
      load_reg <= 1'b0;
      acc_clear_reg <= eq_fire;
      unique case (state_reg)
        dds_pkg::ST_IDLE: begin
          if (pending_reg) begin
            div_num <= tw_num(par_reg[0][0]);
            div_den <= dds_pkg::SYNTH_CLK_HZ;
            div_start <= 1'b1;
            state_reg <= dds_pkg::ST_DIV_A;
          end
        end
        dds_pkg::ST_DIV_A: begin
          if (div_done) begin
            word_calc[0] <= div_quot[WW-1:0];
            div_num <= tw_num(par_reg[1][0]);
            div_start <= 1'b1;
            state_reg <= dds_pkg::ST_DIV_B;
          end
        end
        dds_pkg::ST_DIV_B: begin
          if (div_done) begin
            word_calc[1] <= div_quot[WW-1:0];
            a_high_reg <= par_reg[0][0] >= par_reg[1][0];
            ratio_ok_reg <= 1'b0;
            if (locked_eff && par_reg[0][0] != 32'h0 && par_reg[1][0] != 32'h0) begin
              div_num <= NW'(par_reg[0][0] >= par_reg[1][0] ? par_reg[0][0] : par_reg[1][0]);
              div_den <= (par_reg[0][0] >= par_reg[1][0]) ? par_reg[1][0] : par_reg[0][0];
              div_start <= 1'b1;
              state_reg <= dds_pkg::ST_RATIO;
            end else begin
              state_reg <= dds_pkg::ST_APPLY;
            end
          end
        end
        dds_pkg::ST_RATIO: begin
          if (div_done) begin
            ratio_ok_reg <= (div_rem == 32'h0);
            ratio_reg <= div_quot[31:0];
            state_reg <= dds_pkg::ST_APPLY;
          end
        end
        dds_pkg::ST_APPLY: begin
          word_act[0] <= word_ld_a;
          word_act[1] <= word_ld_b;
          load_reg <= 1'b1;
          acc_clear_reg <= locked_eff | eq_fire;
          state_reg <= dds_pkg::ST_IDLE;
        end
        default: state_reg <= dds_pkg::ST_IDLE;
      endcase
    end
  end

  tw_divider #(.NUM_W(NW), .DEN_W(32)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quot(div_quot),
    .rem(div_rem)
  );

  // Two synthesis channels
  for (genvar c = 0; c < 2; c++) begin : g_ch
    dds_channel #(.WORD_W(WW), .SAMP_W(SW)) u_ch (
      .pclk(pclk),
      .presetn(presetn),
      .word_load(load_reg),
      .word_in(word_act[c]),
      .acc_clear(acc_clear_reg),
      .amp(par_reg[c][1][15:0]),
      .phase_off(par_reg[c][2][15:0]),
      .phase_now(phase_now[c]),
      .sample(samp[c])
    );
  end

  // Same cycle sum with saturation
  assign sum_w = {samp[0][SW-1], samp[0]} + {samp[1][SW-1], samp[1]};
  assign sum_sat = (sum_w[SW] != sum_w[SW-1]) ? (sum_w[SW] ? SAT_MIN : SAT_MAX) :
                   sum_w[SW-1:0];

  // Port routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_sample <= '0;
      port2_sample <= '0;
    end else begin
      port1_sample <= ctrl_reg[dds_pkg::CTRL_SEL1] ? sum_sat : samp[0];
      port2_sample <= ctrl_reg[dds_pkg::CTRL_SEL2] ? sum_sat : samp[1];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  indep_keep_a: assert property (wr_fire && par_hit && !wr_ch && link == dds_pkg::LINK_NONE
    |=> $stable(b_params)) else $error("channel B disturbed");
  lock_reset_a: assert property (timing_wr && locked_eff |-> ##[1:300] acc_clear_reg)
    else $error("no joint restart in locked mode");
  ratio_word_a: assert property (state_reg == dds_pkg::ST_APPLY && ratio_ok_reg && a_high_reg
    |=> word_act[0] == WW'(ratio_reg * word_act[1])) else $error("word not a multiple");
  equal_phase_a: assert property (eq_fire |-> ##2 phase_now[0] == phase_now[1])
    else $error("phases differ after equal phase");
  port_route_a: assert property (!ctrl_reg[dds_pkg::CTRL_SEL2] |=> port2_sample == $past(samp[1]))
    else $error("port two not channel B");
  sum_sat_a: assert property (ctrl_reg[dds_pkg::CTRL_SEL1] && !samp[0][SW-1] && !samp[1][SW-1]
    |=> !port1_sample[SW-1]) else $error("sum wrapped");
  track_dup_a: assert property (wr_fire && par_hit && link == dds_pkg::LINK_TRACK
    |=> a_params == b_params) else $error("tracked channels differ");
  track_reject_a: assert property (wr_fire && par_hit && wr_ch && link == dds_pkg::LINK_TRACK
    |-> pslverr ##1 $stable(b_params)) else $error("channel B write not rejected");
  couple_freq_a: assert property (wr_fire && par_hit && !wr_ch && wr_par == dds_pkg::PAR_FREQ &&
    link == dds_pkg::LINK_COUPLE |=> par_reg[1][0] == xform($past(pwdata), $past(cpl_reg[0]),
    $past(ctrl_reg[dds_pkg::CTRL_KIND]), 1'b1)) else $error("coupled frequency wrong");
  copy_once_a: assert property (copy_ab |=> b_params == $past(a_params))
    else $error("copy incomplete");

  sum_clip_c: cover property (ctrl_reg[dds_pkg::CTRL_SEL1] && sum_w[SW] != sum_w[SW-1]);
  ratio_lock_c: cover property (state_reg == dds_pkg::ST_APPLY && ratio_ok_reg);
  track_rej_c: cover property (wr_fire && par_hit && reject_b);
endmodule
`default_nettype wire

//--- testbench/dac_model.sv
// Converter model that latches each sample word on the clock
`timescale 1ns/1ps
`default_nettype none
module dac_model (
  input wire logic pclk, // Sample clock
  input wire logic presetn, // Async reset, active low
  input wire logic signed [15:0] code_in, // Sample from port
  output logic signed [15:0] code_out // Latched code
);
  // Latch one code per cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) code_out <= 16'sh0000;
    else code_out <= code_in;
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the dual channel coordinator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic [31:0] d; logic e; logic c;} exp_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, samp_on = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr;
  logic signed [15:0] p1, p2, d1, d2;
  int failures = 0, compares = 0, cycles = 0;
  logic [51:0] wa, wb;
  exp_t q[$];
  dual_dds_coordinator DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port1_sample(p1), .port2_sample(p2));
  dac_model dac1 (.pclk(pclk), .presetn(presetn), .code_in(p1), .code_out(d1));
  dac_model dac2 (.pclk(pclk), .presetn(presetn), .code_in(p2), .code_out(d2));
  // Clock and hang guard
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic check_bus(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic check_samp(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Expected word: rounded f * 2^52 / synthesis clock
  function automatic logic [51:0] word_of(input logic [31:0] f);
    logic [95:0] n;
    n = ({64'h0, f} << 52) + 96'(dds_pkg::SYNTH_CLK_HZ >> 1);
    return 52'(n / 96'(dds_pkg::SYNTH_CLK_HZ));
  endfunction
  function automatic logic [15:0] sat2(input logic signed [15:0] v);
    logic [16:0] s;
    s = {v[15], v} + {v[15], v};
    if (s[16] != s[15]) return s[16] ? 16'h8000 : 16'h7FFF;
    return s[15:0];
  endfunction
  // APB master, one idle cycle between transfers
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
    input logic [31:0] e, input logic ee, input logic c);
    @(posedge pclk);
    q.push_back('{e, ee, c});
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1, d, 32'h0, 0, 1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 0, 32'h0, e, 0, 1);
  endtask
  task automatic rdw(input logic [7:0] a, input logic [51:0] w);
    rd(a, w[31:0]);
    rd(a + 8'h04, {12'h000, w[51:32]});
  endtask
  // Wait until busy and pending clear
  task automatic settle();
    int i;
    for (i = 0; i < 200; i++) begin
      apb(dds_pkg::OFS_STATUS, 0, 32'h0, 32'h0, 0, 0);
      if (r[1:0] === 2'b00) break;
    end
  endtask
  // Bus result monitor, oldest note against each completed transfer
  always @(posedge pclk) begin
    exp_t x;
    if (psel && penable && pready) begin
      x = q.pop_front();
      if (x.c) check_bus("pslverr", {31'h0, x.e}, {31'h0, pslverr});
      if (x.c && !pwrite) check_bus("prdata", x.d, prdata);
    end
    if (samp_on) check_samp("port1", sat2(d2), d1);
  end
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    logic [31:0] fa, fb;
    void'($urandom(32'h7E42));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rd(dds_pkg::OFS_CTRL, 32'h0);
    rd(dds_pkg::OFS_PAR_A + 8'h04, 32'h0000FFFF);
    rd(dds_pkg::OFS_CPL_FREQ, 32'h01000100);
    apb(8'hFC, 0, 32'h0, 32'h0, 1, 1);
    fa = $urandom_range(1, 100000000);
    fb = $urandom_range(1, 100000000);
    wr(dds_pkg::OFS_PAR_B, fb);
    settle();
    wr(dds_pkg::OFS_PAR_A, fa);
    settle();
    rdw(dds_pkg::OFS_WA_LO, word_of(fa));
    rdw(dds_pkg::OFS_WB_LO, word_of(fb));
    // Locked mode, tenfold frequency pair
    wr(dds_pkg::OFS_CTRL, 32'h01);
    wr(dds_pkg::OFS_PAR_A, 32'd1000000);
    wr(dds_pkg::OFS_PAR_B, 32'd10000000);
    settle();
    wa = word_of(32'd1000000);
    wb = 52'(wa * 10);
    rdw(dds_pkg::OFS_WB_LO, wb);
    // Locked mode with channel A the higher, twofold
    wr(dds_pkg::OFS_PAR_A, 32'd20000000);
    settle();
    rdw(dds_pkg::OFS_WA_LO, 52'(word_of(32'd10000000) * 2));
    // One-shot copy then divergence
    wr(dds_pkg::OFS_CTRL, 32'h00);
    wr(dds_pkg::OFS_PAR_B, 32'd5);
    wr(dds_pkg::OFS_CMD, 32'h02);
    settle();
    rd(dds_pkg::OFS_PAR_B, 32'd20000000);
    wr(dds_pkg::OFS_PAR_A, 32'd2000000);
    settle();
    rd(dds_pkg::OFS_PAR_B, 32'd20000000);
    // Coupling: amplitude ratio, phase offset, frequency unity ratio
    wr(dds_pkg::OFS_CTRL, 32'h84);
    wr(dds_pkg::OFS_CPL_AMP, 32'h01000080);
    wr(dds_pkg::OFS_CPL_PH, 32'h00000010);
    wr(dds_pkg::OFS_PAR_A + 8'h04, 32'h1000);
    wr(dds_pkg::OFS_PAR_A + 8'h08, 32'h0100);
    wr(dds_pkg::OFS_PAR_A, 32'd3000000);
    settle();
    rd(dds_pkg::OFS_PAR_B + 8'h04, 32'h0800);
    rd(dds_pkg::OFS_PAR_B + 8'h08, 32'h0110);
    rd(dds_pkg::OFS_PAR_B, 32'd3000000);
    // Tracking with port one on the sum
    wr(dds_pkg::OFS_CTRL, 32'h0A);
    settle();
    apb(dds_pkg::OFS_PAR_B + 8'h04, 1, 32'h0001, 32'h0, 1, 1);
    apb(dds_pkg::OFS_STATUS, 0, 32'h0, 32'h0, 0, 0);
    check_bus("locked", 32'h1, {31'h0, r[3]});
    wr(dds_pkg::OFS_PAR_A + 8'h04, 32'hFFFF);
    rd(dds_pkg::OFS_PAR_B + 8'h04, 32'hFFFF);
    wr(dds_pkg::OFS_CMD, 32'h01);
    settle();
    repeat (4) @(posedge pclk);
    samp_on <= 1;
    repeat (200) @(posedge pclk);
    samp_on <= 0;
    end_of_test();
  end
endmodule
`default_nettype wire
